// ==== hdl/timing_map.vh ====
// Purpose: Constants for the instruction length and cycle timing decoder
// Assumes: Standard 8051 opcode map
// Notes: Counts are system clock cycles
`ifndef TIMING_MAP_VH
`define TIMING_MAP_VH
`define CLK_PERIOD_NS 10
`define CYC_MUL 4'h4
`define CYC_DIV 4'h8
`define CYC_MOVX 4'h3
`define CYC_MOVC_PC 4'h3
`define CYC_MOVC_DP_MIN 4'h4
`define CYC_MOVC_DP_MAX 4'h7
`define CYC_INDIRECT 4'h2
`define FLASH_TIMING_W 2
`define FLASH_TIMING_RESET 2'h0
`define OP_MUL 8'ha4
`define OP_DIV 8'h84
`define OP_MOVC_DP 8'h93
`define OP_MOVC_PC 8'h83
`define OP_MOV_DP 8'h90
`define OP_INC_DP 8'ha3
`define OP_DA 8'hd4
`endif

// ==== hdl/op_length.v ====
// Purpose: Byte length and base cycle count of one opcode
// Assumes: Standard 8051 encoding
// Notes: Purely combinational; variable rows flagged separately
`timescale 1ns/100ps
`include "timing_map.vh"
module op_length (
    input wire [7:0] opcode,
    output reg [1:0] nbytes,
    output reg [3:0] ncycles,
    output reg variable,
    output reg branch
);
    wire [3:0] lo = opcode[3:0];
    wire [3:0] hi = opcode[7:4];
    always @* begin
        nbytes = 2'h1;
        ncycles = 4'h1;
        variable = 1'b0;
        branch = 1'b0;
        if (lo >= 4'h8) begin
            // Register operand forms
            nbytes = ((hi == 4'h7) || (hi == 4'ha) || (hi == 4'h8)) ? 2'h2 : 2'h1;
            ncycles = {2'h0, nbytes};
            if (hi == 4'hb || hi == 4'hd) begin
                nbytes = (hi == 4'hb) ? 2'h3 : 2'h2;
                branch = 1'b1;
                ncycles = {2'h0, nbytes};
            end
        end else if (lo == 4'h6 || lo == 4'h7) begin
            // Indirect RAM forms
            nbytes = ((hi == 4'h8) || (hi == 4'ha) || (hi == 4'h7)) ? 2'h2 : 2'h1;
            ncycles = `CYC_INDIRECT;
            if (hi == 4'hb) begin
                nbytes = 2'h3;
                branch = 1'b1;
                ncycles = 4'h3;
            end
        end else if (lo == 4'h5) begin
            nbytes = (hi == 4'h8 || hi == 4'h7 || hi == 4'h5 || hi == 4'h4 || hi == 4'h6)
                ? ((hi == 4'h8 || hi == 4'h7) ? 2'h3 : 2'h2) : 2'h2;
            if (hi == 4'h8 || hi == 4'h7)
                nbytes = 2'h3;
            if (hi == 4'hb || hi == 4'hd) begin
                nbytes = 2'h3;
                branch = 1'b1;
            end
            ncycles = {2'h0, nbytes};
        end else if (lo == 4'h4) begin
            // Divide sits among the immediate forms but has no operand byte
            nbytes = (hi >= 4'h2 && hi <= 4'h9 && hi != 4'h8) ? 2'h2 : 2'h1;
            if (hi == 4'hb) begin
                nbytes = 2'h3;
                branch = 1'b1;
            end
            ncycles = {2'h0, nbytes};
            if (opcode == `OP_MUL)
                ncycles = `CYC_MUL;
            if (opcode == `OP_DIV)
                ncycles = `CYC_DIV;
            if (opcode == `OP_DA)
                ncycles = 4'h1;
        end else if (lo == 4'h3) begin
            nbytes = (hi >= 4'h4 && hi <= 4'h6) ? 2'h3 : 2'h1;
            ncycles = {2'h0, nbytes};
            if (hi >= 4'he)
                ncycles = `CYC_MOVX;
            if (opcode == `OP_MOVC_PC)
                ncycles = `CYC_MOVC_PC;
            if (opcode == `OP_MOVC_DP) begin
                ncycles = `CYC_MOVC_DP_MIN;
                variable = 1'b1;
            end
            if (opcode == `OP_INC_DP)
                ncycles = 4'h1;
        end else if (lo == 4'h2) begin
            nbytes = (hi == 4'h0 || hi == 4'h1) ? 2'h3 : 2'h2;
            if (hi >= 4'he) begin
                nbytes = 2'h1;
                ncycles = `CYC_MOVX;
            end else
                ncycles = {2'h0, nbytes};
            if (hi == 4'h2 || hi == 4'h3)
                ncycles = 4'h1;
            if (hi == 4'h2 || hi == 4'h3)
                nbytes = 2'h1;
        end else if (lo == 4'h0) begin
            // Bit-test branches carry bit and offset, so length is fixed before cycles
            nbytes = (hi == 4'h9 || (hi >= 4'h1 && hi <= 4'h3)) ? 2'h3 : 2'h2;
            if (hi == 4'h0 || hi == 4'he || hi == 4'hf)
                nbytes = 2'h1;
            if (hi == 4'he || hi == 4'hf)
                ncycles = `CYC_MOVX;
            else
                ncycles = {2'h0, nbytes};
            branch = (hi >= 4'h1 && hi <= 4'h7);
        end else begin
            // Absolute jump and call rows
            nbytes = 2'h2;
            ncycles = 4'h2;
        end
    end
endmodule // op_length

// ==== hdl/movc_delay.v ====
// Purpose: Total clock count of a code read at accumulator plus data pointer
// Assumes: Flash read timing setting and target alignment known at issue
// Notes: Result is clamped to the documented window
`timescale 1ns/100ps
`include "timing_map.vh"
module movc_delay (
    input wire [`FLASH_TIMING_W-1:0] flash_read_timing,
    input wire [15:0] target,
    output wire [3:0] cycles
);
    wire [3:0] raw;
    assign raw = `CYC_MOVC_DP_MIN + {2'h0, flash_read_timing} + {3'h0, target[0]};
    assign cycles = (raw > `CYC_MOVC_DP_MAX) ? `CYC_MOVC_DP_MAX : raw;
endmodule // movc_delay

// ==== hdl/instr_timing.v ====
// Purpose: Sequence instruction fetch and count execution cycles per opcode
// Assumes: Opcode and operands presented by program memory on the same clock
// Notes: Issues one instruction at a time; no machine cycles exist
`timescale 1ns/100ps
`include "timing_map.vh"
// Function
// - Opcodes decode with standard 8051 encoding and modes into length and clocks.
// - Durations count whole system clocks only, no machine cycles.
// - Most instructions take as many clocks as program bytes.
// - Untaken conditional branch finishes one clock before taken.
// - Arithmetic: register 1/1, direct or immediate 2/2, indirect 1/2.
// - Logic ops follow arithmetic; to-direct 2/2, immediate-to-direct 3/3.
// - Clear, rotate and swap accumulator: one byte, one clock.
// - Moves: register 1/1, direct or immediate 2/2, direct-to-direct 3/3.
// - Indirect-destination moves take two clocks; indirect-to-direct 2/2.
// - Loading the data pointer immediate takes three bytes, three clocks.
// - Code read via data pointer: one byte, four to seven clocks.
// - Code read via program counter: one byte, three clocks.
// - External data reads and writes: one byte, three clocks.
// - Push and pop direct: two bytes, two clocks.
// - Exchange: register 1/1, direct 2/2, indirect and nibble 1/2.
// - Some counts vary with alignment and flash read timing.
module instr_timing (
    input wire CLK,
    input wire NRST,
    input wire CE,
    input wire START,
    input wire [7:0] OPCODE,
    input wire [15:0] PC,
    input wire [7:0] ACC,
    input wire [15:0] DATA_POINTER,
    input wire [`FLASH_TIMING_W-1:0] FLASH_READ_TIMING,
    input wire BRANCH_TAKEN,
    output reg BUSY,
    output reg DONE,
    output reg [1:0] LENGTH,
    output reg [3:0] CYCLES,
    output reg [15:0] NEXT_PC
);
    localparam ST_IDLE = 2'b01;
    localparam ST_EXEC = 2'b10;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [3:0] count_reg;
    reg [3:0] count_next;
    reg [3:0] total;
    wire [1:0] nbytes;
    wire [3:0] ncycles;
    wire variable;
    wire branch;
    wire [3:0] movc_cycles;
    wire [15:0] movc_target = DATA_POINTER + {8'h00, ACC};

    op_length u_len (
        .opcode(OPCODE),
        .nbytes(nbytes),
        .ncycles(ncycles),
        .variable(variable),
        .branch(branch)
    );

    movc_delay u_movc (
        .flash_read_timing(FLASH_READ_TIMING),
        .target(movc_target),
        .cycles(movc_cycles)
    );

    always @* begin
        total = ncycles;
        if (variable)
            total = movc_cycles;
        if (branch && BRANCH_TAKEN)
            total = ncycles + 4'h1;
    end

    always @* begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            ST_IDLE: begin
                if (START) begin
                    count_next = total - 4'h1;
                    state_next = (total == 4'h1) ? ST_IDLE : ST_EXEC;
                end
            end
            ST_EXEC: begin
                count_next = count_reg - 4'h1;
                if (count_reg == 4'h1)
                    state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
                count_next = 4'h0;
            end
        endcase
    end

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg <= ST_IDLE;
            count_reg <= 4'h0;
            BUSY <= 1'b0;
            DONE <= 1'b0;
            LENGTH <= 2'h0;
            CYCLES <= 4'h0;
            NEXT_PC <= 16'h0000;
        end else if (CE) begin
            state_reg <= state_next;
            count_reg <= count_next;
            BUSY <= (state_next == ST_EXEC);
            // Done marks the last clock of the instruction
            DONE <= (state_reg == ST_IDLE && START && total == 4'h1)
                || (state_reg == ST_EXEC && count_reg == 4'h1);
            if (state_reg == ST_IDLE && START) begin
                LENGTH <= nbytes;
                CYCLES <= total;
                NEXT_PC <= PC + {14'h0000, nbytes};
            end
        end
    end
endmodule // instr_timing

// ==== sim/code_rom.sv ====
// Purpose: Program memory model feeding opcodes to the decoder
// Assumes: Synthetic image: the byte at address a is a[15:8]
// Notes: Combinational read, so opcode and PC share one clock
`timescale 1ns/100ps
module code_rom (
    input wire [15:0] addr,
    output wire [7:0] data
);
    assign data = addr[15:8];
endmodule // code_rom

// ==== sim/instr_timing_asserts.sv ====
// Purpose: Port timing checks for the instruction timing decoder
// Assumes: START may stay high while busy; it is taken only when idle or in the DONE cycle
// Notes: Issue tracking mirrors the documented start acceptance
`timescale 1ns/100ps
`include "timing_map.vh"
module timing_checker (
    input wire CLK,
    input wire NRST,
    input wire CE,
    input wire START,
    input wire [7:0] OPCODE,
    input wire BRANCH_TAKEN,
    input wire DONE,
    input wire [1:0] LENGTH,
    input wire [3:0] CYCLES
);
    reg act_reg;
    wire issue = CE && START && (!act_reg || DONE);
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) act_reg <= 1'b0;
        else if (issue || DONE) act_reg <= issue;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    a_mul_count: assert property (issue && OPCODE == `OP_MUL |=> LENGTH == 2'h1 &&
        CYCLES == `CYC_MUL) else $error("multiply count wrong");
    a_mul_done: assert property (issue && OPCODE == `OP_MUL |=> !DONE [*3] ##1 DONE)
        else $error("multiply done timing wrong");
    a_one_done: assert property (issue ##1 CYCLES == 4'h1 |-> DONE)
        else $error("single clock op not done");
    a_two_done: assert property (issue ##1 CYCLES == 4'h2 |-> !DONE ##1 DONE)
        else $error("two clock op done timing wrong");
    a_branch_count: assert property (issue && OPCODE == 8'h60 |=>
        CYCLES == ($past(BRANCH_TAKEN) ? 4'h3 : 4'h2)) else $error("branch count wrong");
    a_xdata_count: assert property (issue && OPCODE[7:5] == 3'h7 &&
        OPCODE[3:0] inside {4'h0, 4'h2, 4'h3} |=> CYCLES == `CYC_MOVX) else $error("xdata");
    a_code_window: assert property (issue && OPCODE == `OP_MOVC_DP |=>
        CYCLES inside {[4'h4:4'h7]}) else $error("code read count outside window");
    a_done_pulse: assert property (CE && DONE && !issue |=> !DONE)
        else $error("done longer than one clock");
    cover property (issue && OPCODE == `OP_DIV);
    cover property (START && !issue);
    cover property (issue && BRANCH_TAKEN);
endmodule // timing_checker
bind instr_timing timing_checker u_chk (.CLK(CLK), .NRST(NRST), .CE(CE), .START(START),
    .OPCODE(OPCODE), .BRANCH_TAKEN(BRANCH_TAKEN), .DONE(DONE), .LENGTH(LENGTH), .CYCLES(CYCLES));

// ==== sim/tb.sv ====
// Purpose: Self-checking bench for the instruction timing decoder
// Assumes: Opcodes come from the code_rom image at PC
// Notes: Tables pack opcode, length and clock count per entry
`timescale 1ns/100ps
`include "timing_map.vh"
module tb;
    reg clk = 1'b0, nrst = 1'b0, start = 1'b0, br = 1'b0, ce = 1'b1;
    reg [15:0] pc = 16'h0, dp = 16'h0;
    reg [7:0] acc = 8'h0;
    reg [1:0] rd_timing = 2'h0;
    wire [7:0] op;
    wire done, busy;
    wire [1:0] len;
    wire [3:0] cyc;
    wire [15:0] npc;
    integer n_mismatch = 0, checks = 0, i;
    always #5 clk = ~clk;
    code_rom u_rom (.addr(pc), .data(op));
    instr_timing u_dut (.CLK(clk), .NRST(nrst), .CE(ce), .START(start), .OPCODE(op), .PC(pc),
        .ACC(acc), .DATA_POINTER(dp), .FLASH_READ_TIMING(rd_timing), .BRANCH_TAKEN(br),
        .BUSY(busy),
        .DONE(done), .LENGTH(len), .CYCLES(cyc), .NEXT_PC(npc));
    task results;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string nm, input [15:0] got, input [15:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // With h set, START stays up during execution on another opcode, which must be ignored
    task go(input [7:0] o, input h, input [1:0] el, input [3:0] ec);
        integer n;
        @(negedge clk);
        pc = {o, 8'h10};
        start = 1'b1;
        @(negedge clk);
        start = h;
        pc = h ? 16'he410 : pc;
        chk("length", len, el);
        chk("cycles", cyc, ec);
        chk("next pc", npc, {o, 8'h10} + el);
        chk("busy", busy, ec > 4'h1);
        for (n = 1; done !== 1'b1 && n < 20; n = n + 1)
            @(negedge clk);
        start = 1'b0;
        chk("held cycles", cyc, ec);
        chk("done delay", n, ec);
        chk("busy at done", busy, 1'b0);
        if (n == 20)
            results;
    endtask
    task tab(input string nm, input [255:0] v);
        for (i = 15; i >= 0; i = i - 1)
            if (v[16*i +: 16] !== 16'h0)
                go(v[16*i+8 +: 8], 1'b0, v[16*i+4 +: 2], v[16*i +: 4]);
        $display("%s done", nm);
    endtask
    task test_code_read;
        reg [3:0] want;
        acc = 8'h01;
        for (i = 0; i < 8; i = i + 1) begin
            rd_timing = i[2:1];
            dp = 16'h00ff + {15'h0, i[0]};
            want = (i[2:1] + i[0] > 3) ? 4'h7 : 4'h4 + i[2:1] + i[0];
            go(`OP_MOVC_DP, 1'b0, 2'h1, want);
        end
        $display("code read done");
    endtask
    task test_branch;
        for (i = 0; i < 4; i = i + 1) begin
            br = i[0];
            go(i[1] ? 8'h70 : 8'h60, 1'b0, 2'h2, 4'h2 + i[0]);
        end
        br = 1'b0;
        $display("branch done");
    endtask
    // Clock enable low mid-instruction must stretch it by exactly the frozen clocks
    task test_freeze;
        integer n;
        @(negedge clk);
        pc = {`OP_MOV_DP, 8'h10};
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        ce = 1'b0;
        repeat (2) @(negedge clk);
        chk("frozen busy", busy, 1'b1);
        chk("frozen done", done, 1'b0);
        ce = 1'b1;
        for (n = 1; done !== 1'b1 && n < 20; n = n + 1)
            @(negedge clk);
        chk("freeze delay", n, 4'h3);
        chk("freeze cycles", cyc, 4'h3);
        chk("freeze busy end", busy, 1'b0);
        $display("freeze done");
        if (n == 20)
            results;
    endtask
    // Reset in the middle of a long instruction clears every output at once
    task test_reset;
        @(negedge clk);
        pc = {`OP_DIV, 8'h10};
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        nrst = 1'b0;
        @(negedge clk);
        chk("reset busy", busy, 1'b0);
        chk("reset done", done, 1'b0);
        chk("reset length", len, 2'h0);
        chk("reset cycles", cyc, 4'h0);
        chk("reset next pc", npc, 16'h0000);
        nrst = 1'b1;
        @(negedge clk);
        chk("done after reset", done, 1'b0);
        $display("mid-run reset test done");
    endtask
    initial begin
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        tab("arith", 144'h2811_2522_2612_2422_3811_9712_0411_0522_1612);
        tab("mul div", 64'ha414_8418_d411_a311);
        tab("logic", 96'h5222_5333_4333_6222_5712_6f11);
        tab("accum", 96'he411_2311_3311_0311_1311_c411);
        tab("moves", 160'he811_f811_e522_7422_8533_7533_f612_a622_7622_8622);
        tab("pointer", 32'h9033);
        tab("xdata", 96'he013_e213_e313_f013_f213_f313);
        tab("stack xch", 96'hc022_d022_c811_c522_c612_d612);
        go(`OP_MOVC_PC, 1'b0, 2'h1, 4'h3);
        go(`OP_DIV, 1'b1, 2'h1, 4'h8);
        test_code_read;
        test_branch;
        test_freeze;
        test_reset;
        go(`OP_MUL, 1'b0, 2'h1, 4'h4);
        results;
    end
endmodule // tb
